// ==== src/ddr_sram_port.sv ====
// Operation
// - Write data is captured on rising edges of both input clocks.
// - Read data is launched, one word per rising edge of either clock.
// - Data outputs float whenever no read is being driven.
// - Load is active low and sampled only on true clock rising edges.
// - Address and direction are taken at the same edge as load.
// - Every transaction moves exactly two words.
// - Eight-bit variant uses two nibble masks for bits 3:0 and 7:4.
// - A deasserted nibble mask leaves that stored nibble unchanged.
// - Each nibble mask is sampled with the data word it qualifies.
// - Byte mask 0 gates bits 8:0, mask 1 gates bits 17:9.
// - Thirty-six-bit variant adds masks for bits 26:18 and 35:27.
// - A deasserted byte mask leaves that stored lane unchanged.
// - Each byte mask is sampled with its own burst word.
// - Direction high at load means read, low means write.
// - One shared address bus, sampled at true clock rising edges.
// - Valid flag is high while read data is driven, aligned to echo.
`timescale 1ns/10ps
module ddr_sram_port (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     k_pin,
	input  wire logic                     k_n_pin,
	input  wire ddr_port_pkg::cmd_pins_t  cmd,
	input  wire ddr_port_pkg::wr_beat_t   wr_in,
	output logic [ddr_port_pkg::DATA_W-1:0] dq_out,
	output logic                          dq_oe,
	output logic                          read_data_valid_flag,
	output logic                          echo_clock_out,
	output logic                          echo_clock_out_n
);
	import ddr_port_pkg::*;

	localparam int         DEPTH       = 2 ** (ADDR_W + 1);
	localparam logic [1:0] SETTLE_DONE = 2'h3;
	localparam logic [1:0] SETTLE_STEP = 2'h1;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0]                    k_sync;
		logic [1:0]                    kn_sync;
		logic                          k_prev;
		logic                          kn_prev;
		cmd_pins_t                     cmd_s1;
		cmd_pins_t                     cmd_s2;
		wr_beat_t                      wr_s1;
		wr_beat_t                      wr_s2;
		xact_t                         pend;
		xact_t                         act;
		logic [ADDR_W-1:0]             rd_addr;
		logic [1:0]                    rd_left;
		logic                          rd_beat;
		logic [DEPTH-1:0][DATA_W-1:0]  mem;
		logic [DATA_W-1:0]             dq_out;
		logic                          dq_oe;
		logic                          valid;
		logic                          echo;
		logic                          echo_n;
		logic [1:0]                    settle;
	} port_state_t;

	port_state_t         s_r;
	port_state_t         s_nxt;
	logic                k_rise;
	logic                kn_rise;
	logic                beat_edge;
	op_t                 b_op;
	logic [ADDR_W:0]     b_idx;
	logic                fifo_in_valid;
	logic                fifo_in_ready;
	logic [DATA_W-1:0]   fifo_in_data;
	logic                fifo_out_valid;
	logic                fifo_pop;
	logic [DATA_W-1:0]   fifo_out_data;

	// Pin inputs pass two flops; edges are seen only on the second
	// Edge history resets low; a pin already high at release is no rise
	// Limitation: a real rise before the first clock edge after release is lost
	assign k_rise        = (s_r.settle == SETTLE_DONE) && s_r.k_sync[1] && !s_r.k_prev;
	assign kn_rise       = (s_r.settle == SETTLE_DONE) && s_r.kn_sync[1] && !s_r.kn_prev;
	assign fifo_in_valid = (s_r.rd_left != WORDS_NONE);
	assign fifo_in_data  = s_r.mem[{s_r.rd_addr, s_r.rd_beat}];

	// ****************************************
	// Read prefetch buffer
	// ****************************************
	// Prefetch runs ahead of the beats; a late beat stalls it, no word lost
	word_buf2 #(
		.W (DATA_W)
	) u_rd_buf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt          = s_r;
		s_nxt.k_sync   = {s_r.k_sync[0], k_pin};
		s_nxt.kn_sync  = {s_r.kn_sync[0], k_n_pin};
		s_nxt.k_prev   = s_r.k_sync[1];
		s_nxt.kn_prev  = s_r.kn_sync[1];
		s_nxt.cmd_s1   = cmd;
		s_nxt.cmd_s2   = s_r.cmd_s1;
		s_nxt.wr_s1    = wr_in;
		s_nxt.wr_s2    = s_r.wr_s1;
		s_nxt.echo     = s_r.k_sync[1];
		s_nxt.echo_n   = s_r.kn_sync[1];
		beat_edge      = k_rise || kn_rise;
		b_op           = OP_IDLE;
		b_idx          = '0;
		fifo_pop       = 1'b0;

		if (s_r.settle != SETTLE_DONE) begin
			s_nxt.settle = s_r.settle + SETTLE_STEP;
		end

		if (fifo_in_valid && fifo_in_ready) begin
			s_nxt.rd_left = s_r.rd_left - 2'h1;
			s_nxt.rd_beat = BEAT_SECOND;
		end

		if (k_rise) begin
			// First beat belongs to the previous load
			b_op          = s_r.pend.op;
			b_idx         = {s_r.pend.addr, BEAT_FIRST};
			s_nxt.act     = s_r.pend;
			s_nxt.pend.op = OP_IDLE;
			if (s_r.cmd_s2.bus_cycle_load_n == LOAD_ACTIVE) begin
				s_nxt.pend.addr = s_r.cmd_s2.addr;
				if (s_r.cmd_s2.dir_read == DIR_READ) begin
					s_nxt.pend.op = OP_READ;
					s_nxt.rd_addr = s_r.cmd_s2.addr;
					s_nxt.rd_left = WORDS_BURST;
					s_nxt.rd_beat = BEAT_FIRST;
				end else begin
					s_nxt.pend.op = OP_WRITE;
				end
			end
		end else if (kn_rise) begin
			b_op         = s_r.act.op;
			b_idx        = {s_r.act.addr, BEAT_SECOND};
			s_nxt.act.op = OP_IDLE;
		end

		if (beat_edge) begin
			if (b_op == OP_WRITE) begin
				// Mask and data come from the same sampled beat
				for (int l = 0; l < LANES; l++) begin
					if (s_r.wr_s2.byte_write_mask_n[l] == MASK_WRITE) begin
						s_nxt.mem[b_idx][l*LANE_W +: LANE_W] =
							s_r.wr_s2.data[l*LANE_W +: LANE_W];
					end
				end
			end
			if (b_op == OP_READ) begin
				fifo_pop     = 1'b1;
				s_nxt.dq_out = fifo_out_data;
				s_nxt.dq_oe  = 1'b1;
				s_nxt.valid  = fifo_out_valid;
			end else begin
				s_nxt.dq_out = '0;
				s_nxt.dq_oe  = 1'b0;
				s_nxt.valid  = 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dq_out               = s_r.dq_out;
	assign dq_oe                = s_r.dq_oe;
	assign read_data_valid_flag = s_r.valid;
	assign echo_clock_out       = s_r.echo;
	assign echo_clock_out_n     = s_r.echo_n;

	// ****************************************
	// Checks
	// ****************************************
	logic [LANE_W-1:0] lane0_stored;
	logic [LANE_W-1:0] lane0_incoming;
	logic              load_read;
	assign lane0_stored   = s_r.mem[b_idx][LANE_W-1:0];
	assign lane0_incoming = s_r.wr_s2.data[LANE_W-1:0];
	assign load_read      = k_rise && s_r.cmd_s2.bus_cycle_load_n == LOAD_ACTIVE
		&& s_r.cmd_s2.dir_read == DIR_READ;

	property p_float_idle;
		@(posedge clock) disable iff (rst)
		(beat_edge && b_op != OP_READ) |=> !dq_oe;
	endproperty
	a_float_idle: assert property (p_float_idle) else $error("bus driven without read");

	property p_drive_read;
		@(posedge clock) disable iff (rst)
		(beat_edge && b_op == OP_READ) |=> dq_oe && dq_out == $past(fifo_out_data);
	endproperty
	a_drive_read: assert property (p_drive_read) else $error("read word not driven");

	property p_valid_with_oe;
		@(posedge clock) disable iff (rst)
		read_data_valid_flag |-> dq_oe;
	endproperty
	a_valid_with_oe: assert property (p_valid_with_oe) else $error("valid without drive");

	property p_load_only_k;
		@(posedge clock) disable iff (rst)
		!k_rise |=> s_r.pend == $past(s_r.pend);
	endproperty
	a_load_only_k: assert property (p_load_only_k) else $error("load taken off k edge");

	property p_load_capture;
		@(posedge clock) disable iff (rst)
		load_read |=> s_r.pend.op == OP_READ && s_r.pend.addr == $past(s_r.cmd_s2.addr);
	endproperty
	a_load_capture: assert property (p_load_capture) else $error("load fields wrong");

	property p_two_words;
		@(posedge clock) disable iff (rst)
		// Second prefetch may wait behind a full buffer until the next beat
		load_read |=> s_r.rd_left == WORDS_BURST ##1 s_r.rd_left == (WORDS_BURST - 2'h1);
	endproperty
	a_two_words: assert property (p_two_words) else $error("burst not two words");

	property p_lane_kept;
		@(posedge clock) disable iff (rst)
		(beat_edge && b_op == OP_WRITE && s_r.wr_s2.byte_write_mask_n[0] != MASK_WRITE)
		|=> s_r.mem[$past(b_idx)][LANE_W-1:0] == $past(lane0_stored);
	endproperty
	a_lane_kept: assert property (p_lane_kept) else $error("masked lane altered");

	property p_lane_written;
		@(posedge clock) disable iff (rst)
		(beat_edge && b_op == OP_WRITE && s_r.wr_s2.byte_write_mask_n[0] == MASK_WRITE)
		|=> s_r.mem[$past(b_idx)][LANE_W-1:0] == $past(lane0_incoming);
	endproperty
	a_lane_written: assert property (p_lane_written) else $error("lane not written");

	property p_second_beat;
		@(posedge clock) disable iff (rst)
		(kn_rise && !k_rise && s_r.act.op == OP_WRITE) |-> b_idx[0] == BEAT_SECOND;
	endproperty
	a_second_beat: assert property (p_second_beat) else $error("second beat misplaced");
endmodule : ddr_sram_port

// ==== shared/ddr_port_pkg.sv ====
package ddr_port_pkg;
	// ****************************************
	// Widths and organisation
	// ****************************************
	localparam int DATA_W    = 36;
	localparam int LANES     = 4;
	localparam int LANE_W    = DATA_W / LANES;
	localparam int ADDR_W    = 4;
	localparam int BURST_LEN = 2;

	// ****************************************
	// Pin levels and encodings
	// ****************************************
	localparam logic       LOAD_ACTIVE = 1'b0;
	localparam logic       DIR_READ    = 1'b1;
	localparam logic       MASK_WRITE  = 1'b0;
	localparam logic       BEAT_FIRST  = 1'b0;
	localparam logic       BEAT_SECOND = 1'b1;
	localparam logic [1:0] WORDS_NONE  = 2'h0;
	localparam logic [1:0] WORDS_BURST = 2'h2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;

	typedef struct packed {
		logic              bus_cycle_load_n;
		logic              dir_read;
		logic [ADDR_W-1:0] addr;
	} cmd_pins_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [LANES-1:0]  byte_write_mask_n;
	} wr_beat_t;

	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] addr;
	} xact_t;
endpackage : ddr_port_pkg

// ==== src/word_buf2.sv ====
`timescale 1ns/10ps
module word_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] slot;
		logic              rd_ptr;
		logic              wr_ptr;
		logic [1:0]        count;
	} buf_state_t;

	localparam logic [1:0] FULL_COUNT = 2'h2;
	localparam logic [1:0] ONE        = 2'h1;

	buf_state_t s_r;
	buf_state_t s_nxt;
	logic       push;
	logic       pop;

	assign in_ready  = (s_r.count != FULL_COUNT);
	assign out_valid = (s_r.count != '0);
	assign out_data  = s_r.slot[s_r.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.slot[s_r.wr_ptr] = in_data;
			s_nxt.wr_ptr           = ~s_r.wr_ptr;
		end
		if (pop) begin
			s_nxt.rd_ptr = ~s_r.rd_ptr;
		end
		if (push && !pop) begin
			s_nxt.count = s_r.count + ONE;
		end else if (pop && !push) begin
			s_nxt.count = s_r.count - ONE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : word_buf2

// ==== test/ctrl_model.sv ====
`timescale 1ns/10ps
module ctrl_model (
	input  wire logic               clock,
	output logic                    k_pin,
	output logic                    k_n_pin,
	output ddr_port_pkg::cmd_pins_t cmd,
	output ddr_port_pkg::wr_beat_t  wr_in
);
	import ddr_port_pkg::*;

	initial begin
		k_pin   = 1'b0;
		k_n_pin = 1'b0;
		cmd     = '{1'b1, 1'b0, '0};
		wr_in   = '0;
	end

	// Unused fields flip each half, so a stale value cannot pass
	task automatic drive_half(
		input logic              kval,
		input logic              ld_n,
		input logic              dir,
		input logic [ADDR_W-1:0] addr,
		input logic              dcare,
		input logic [DATA_W-1:0] data,
		input logic [LANES-1:0]  mask
	);
		@(negedge clock);
		cmd.bus_cycle_load_n = ld_n;
		cmd.dir_read = ld_n ? ~cmd.dir_read : dir;
		cmd.addr = ld_n ? ~cmd.addr : addr;
		wr_in.data = dcare ? data : ~wr_in.data;
		wr_in.byte_write_mask_n = dcare ? mask : ~wr_in.byte_write_mask_n;
		// Pins are synchronised inside, so hold a few cycles each side
		repeat (4) @(negedge clock);
		k_pin   = kval;
		k_n_pin = ~kval;
		repeat (6) @(negedge clock);
	endtask : drive_half
endmodule : ctrl_model

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	import ddr_port_pkg::*;

	typedef struct packed {
		logic              ld_n;
		logic              dir;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] d0;
		logic [LANES-1:0]  m0;
		logic [DATA_W-1:0] d1;
		logic [LANES-1:0]  m1;
	} row_t;

	localparam logic [DATA_W-1:0] ZERO = '0;
	localparam logic [DATA_W-1:0] ONES = '1;
	localparam logic [DATA_W-1:0] W6A  = {9'h0AB, 9'h1CD, 9'h0EF, 9'h101};
	localparam logic [DATA_W-1:0] W6B  = {9'h1FE, 9'h0DC, 9'h1BA, 9'h010};
	localparam logic [DATA_W-1:0] M3A  = {9'h1A1, 9'h122, 9'h1C3, 9'h144};
	localparam logic [DATA_W-1:0] M3B  = {9'h011, 9'h0F2, 9'h033, 9'h0F4};
	localparam int                N_ROWS = 10;
	// For read rows the data fields hold the words expected back
	localparam row_t rows [N_ROWS] = '{
		'{1'b0, 1'b0, 4'h3, {9'h1A1, 9'h1B2, 9'h1C3, 9'h1D4}, 4'h0,
			{9'h0F1, 9'h0F2, 9'h0F3, 9'h0F4}, 4'h0},
		'{1'b0, 1'b0, 4'h3, {9'h111, 9'h122, 9'h133, 9'h144}, 4'hA,
			{9'h011, 9'h022, 9'h033, 9'h044}, 4'h5},
		'{1'b0, 1'b1, 4'h3, M3A, 4'h0, M3B, 4'h0},
		'{1'b1, 1'b0, 4'h3, ZERO, 4'h0, ZERO, 4'h0},
		'{1'b0, 1'b1, 4'h3, M3A, 4'h0, M3B, 4'h0},
		'{1'b0, 1'b0, 4'hC, ONES, 4'hF, ONES, 4'hF},
		'{1'b0, 1'b1, 4'hC, ZERO, 4'h0, ZERO, 4'h0},
		'{1'b0, 1'b0, 4'hF, ONES, 4'h0, ZERO, 4'h0},
		'{1'b0, 1'b1, 4'hF, ONES, 4'h0, ZERO, 4'h0},
		'{1'b0, 1'b1, 4'h0, ZERO, 4'h0, ZERO, 4'h0}
	};

	logic                     clock;
	logic                     rst;
	logic                     k_pin;
	logic                     k_n_pin;
	cmd_pins_t                cmd;
	wr_beat_t                 wr_in;
	logic [DATA_W-1:0]        dq_out;
	logic                     dq_oe;
	logic                     read_data_valid_flag;
	logic                     echo_clock_out;
	logic                     echo_clock_out_n;
	int                       n_errors;
	int                       n_compared;

	ctrl_model u_ctrl_model (.clock(clock), .k_pin(k_pin), .k_n_pin(k_n_pin),
		.cmd(cmd), .wr_in(wr_in));
	ddr_sram_port u_ddr_sram_port (.clock(clock), .rst(rst), .k_pin(k_pin),
		.k_n_pin(k_n_pin), .cmd(cmd), .wr_in(wr_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.read_data_valid_flag(read_data_valid_flag), .echo_clock_out(echo_clock_out),
		.echo_clock_out_n(echo_clock_out_n));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// ****************************************
	// One pin half period, then look at the settled outputs
	// ****************************************
	task automatic half(input logic kval, input logic ld_n, input logic dir,
		input logic [ADDR_W-1:0] addr, input logic dcare, input logic [DATA_W-1:0] data,
		input logic [LANES-1:0] mask, input logic exp_oe, input logic [DATA_W-1:0] exp_q);
		u_ctrl_model.drive_half(kval, ld_n, dir, addr, dcare, data, mask);
		`CHECK(dq_oe, exp_oe)
		`CHECK(read_data_valid_flag, exp_oe)
		`CHECK(dq_out, exp_q)
		`CHECK(echo_clock_out, kval)
		`CHECK(echo_clock_out_n, ~kval)
	endtask : half

	task automatic burst(input row_t r);
		logic rd;
		rd = !r.ld_n && r.dir;
		half(1'b1, r.ld_n, r.dir, r.addr, 1'b0, ZERO, 4'h0, 1'b0, ZERO);
		half(1'b0, 1'b1, 1'b0, 4'h0, 1'b0, ZERO, 4'h0, 1'b0, ZERO);
		half(1'b1, 1'b1, 1'b0, 4'h0, !rd, r.d0, r.m0, rd, rd ? r.d0 : ZERO);
		half(1'b0, 1'b1, 1'b0, 4'h0, !rd, r.d1, r.m1, rd, rd ? r.d1 : ZERO);
	endtask : burst

	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		n_errors   = 0;
		n_compared = 0;
		rst        = 1'b1;
		repeat (12) @(negedge clock);
		`CHECK(dq_oe, 1'b0)
		`CHECK(dq_out, ZERO)
		rst = 1'b0;
		$display("test done: reset");
		for (int i = 0; i < N_ROWS; i++) begin
			burst(rows[i]);
			$display("test done: row %0d", i);
		end
		// Read loaded on the true edge that carries the write's first word
		half(1'b1, 1'b0, 1'b0, 4'h6, 1'b0, ZERO, 4'h0, 1'b0, ZERO);
		half(1'b0, 1'b1, 1'b0, 4'h0, 1'b0, ZERO, 4'h0, 1'b0, ZERO);
		half(1'b1, 1'b0, 1'b1, 4'h3, 1'b1, W6A, 4'h0, 1'b0, ZERO);
		half(1'b0, 1'b1, 1'b0, 4'h0, 1'b1, W6B, 4'h0, 1'b0, ZERO);
		half(1'b1, 1'b1, 1'b0, 4'h0, 1'b0, ZERO, 4'h0, 1'b1, M3A);
		half(1'b0, 1'b1, 1'b0, 4'h0, 1'b0, ZERO, 4'h0, 1'b1, M3B);
		burst('{1'b0, 1'b1, 4'h6, W6A, 4'h0, W6B, 4'h0});
		$display("test done: back to back");
		@(negedge clock);
		rst = 1'b1;
		@(negedge clock);
		`CHECK(dq_oe, 1'b0)
		`CHECK(echo_clock_out_n, 1'b0)
		rst = 1'b0;
		burst('{1'b0, 1'b1, 4'h3, ZERO, 4'h0, ZERO, 4'h0});
		$display("test done: reset in mid run");
		end_of_test();
	end
endmodule : testbench
